//--- rtl/gpio_port_pkg.sv
package gpio_port_pkg;
  // Pin population
  localparam int NPINS = 13;
  localparam int NGPIO = 5;
  localparam int NLED  = 8;

  // Register indices on the command port
  localparam logic [3:0] ADDR_CMD_TYPE  = 4'h0;
  localparam logic [3:0] ADDR_ARG0      = 4'h1;
  localparam logic [3:0] ADDR_ARG1      = 4'h2;
  localparam logic [3:0] ADDR_ARG2      = 4'h3;
  localparam logic [3:0] ADDR_EXEC      = 4'h4;
  localparam logic [3:0] ADDR_RESP_TYPE = 4'h5;
  localparam logic [3:0] ADDR_RESP_LEN  = 4'h6;
  localparam logic [3:0] ADDR_RESP0     = 4'h7;
  localparam logic [3:0] ADDR_RESP1     = 4'h8;
  localparam logic [3:0] ADDR_RESP2     = 4'h9;
  localparam logic [3:0] ADDR_RESP3     = 4'ha;

  // Packet type codes
  localparam logic [7:0] CMD_STORE  = 8'h04;
  localparam logic [7:0] CMD_SET    = 8'h22;
  localparam logic [7:0] CMD_QUERY  = 8'h23;
  localparam logic [7:0] RESP_FLAG  = 8'h40;
  localparam logic [7:0] ERR_FLAG   = 8'hc0;

  // Payload lengths
  localparam logic [1:0] LEN_STORE  = 2'h0;
  localparam logic [1:0] LEN_QUERY  = 2'h1;
  localparam logic [1:0] LEN_VALUE  = 2'h2;
  localparam logic [1:0] LEN_CONFIG = 2'h3;
  localparam logic [2:0] RLEN_NONE  = 3'h0;
  localparam logic [2:0] RLEN_QUERY = 3'h4;

  // Payload fields
  localparam logic [7:0] IDX_MAX       = 8'h0c;
  localparam logic [7:0] VAL_LOW       = 8'h00;
  localparam logic [7:0] VAL_HIGH      = 8'h64;
  localparam logic [7:0] CFG_RSVD_MASK = 8'hf0;
  localparam int         CFG_FUNC_BIT  = 3;

  // Drive mode codes
  localparam logic [2:0] MODE_HI_PD   = 3'h0;
  localparam logic [2:0] MODE_STRONG  = 3'h1;
  localparam logic [2:0] MODE_HIZ     = 3'h2;
  localparam logic [2:0] MODE_PU_LO   = 3'h3;
  localparam logic [2:0] MODE_SHI_Z   = 3'h4;
  localparam logic [2:0] MODE_SLOW    = 3'h5;
  localparam logic [2:0] MODE_RSVD    = 3'h6;
  localparam logic [2:0] MODE_Z_SLO   = 3'h7;

  // Factory settings: sense pin as input, control pins driving
  localparam logic [7:0] FACTORY_VALUE   = 8'h00;
  localparam logic [3:0] FACTORY_CFG     = 4'h2;
  localparam logic [3:0] FACTORY_CFG_DRV = 4'h1;

  // Timing
  localparam int CLK_PERIOD_NS    = 5;
  localparam int PWM_PERIOD_NS    = 10_000_000;
  localparam int PWM_STEPS        = 100;
  localparam int SAMPLE_PERIOD_NS = 31_250_000;
  localparam int PWM_STEP_CYCLES  = PWM_PERIOD_NS / (CLK_PERIOD_NS * PWM_STEPS);
  localparam int SAMPLE_CYCLES    = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;

  function automatic logic [3:0] factory_cfg(input int i);
    factory_cfg = (i == 2 || i == 3) ? FACTORY_CFG_DRV : FACTORY_CFG;
  endfunction : factory_cfg
endpackage : gpio_port_pkg

//--- rtl/packet_gpio_port.sv
`timescale 1ns/1ps
// Functional notes
// - Five bidirectional pins, each input or output, shared with host power functions.
// - Output drives high, low, or 100 Hz PWM with programmable duty.
// - Every pin sampled at 32 Hz; last sample reported as state.
// - Rising and falling edges between samples latched since last query.
// - Pull-up mode with floating pin reads one, grounded reads zero.
// - Set command 0x22: two bytes value only, three bytes adds configuration.
// - Index 0-4 bidirectional pins, 5-12 LED dies, 13 and up rejected.
// - Value 0 low, 1-99 duty percent, 100 high, above invalid.
// - Drive modes decode to strong, slow, resistive and high-impedance levels.
// - Drive mode 110 rejected with an error response.
// - Function bit on pins 0-4: zero default function, one user control.
// - Pin 1 senses host power, pin 2 power control, pin 3 reset.
// - Pin configuration saved by store command and restored after each rst_n reset; power-on returns it to factory.
// - Successful set answered with type 0x62 and empty payload.
// - Query 0x23 carries one byte pin index, same numbering as set.
// - Query answer 0x63: index, state byte, value, configuration.
// - State byte: bit 0 level, bit 1 falling, bit 2 rising.
module packet_gpio_port #(
  parameter int PWM_STEP = gpio_port_pkg::PWM_STEP_CYCLES,
  parameter int SAMPLE   = gpio_port_pkg::SAMPLE_CYCLES
) (
  // Clock and resets
  input  wire logic                             clock,
  input  wire logic                             rst_n,
  input  wire logic                             por_n,
  // Command port
  input  wire logic [3:0]                       addr,
  input  wire logic [7:0]                       wdata,
  input  wire logic                             wr_en,
  input  wire logic                             rd_en,
  output logic      [7:0]                       rdata,
  // Bidirectional pins
  input  wire logic [gpio_port_pkg::NGPIO-1:0]  gpio_in,
  output logic      [gpio_port_pkg::NGPIO-1:0]  gpio_out,
  output logic      [gpio_port_pkg::NGPIO-1:0]  gpio_oe,
  output logic      [gpio_port_pkg::NGPIO-1:0]  gpio_pull_up,
  output logic      [gpio_port_pkg::NGPIO-1:0]  gpio_pull_down,
  output logic      [gpio_port_pkg::NGPIO-1:0]  gpio_slow,
  // LED dies
  output logic      [gpio_port_pkg::NLED-1:0]   led_out,
  // Default host power function
  input  wire logic [gpio_port_pkg::NGPIO-1:0]  dflt_level,
  output logic                                  host_power_sense
);
  import gpio_port_pkg::*;

  localparam int STEP_W = $clog2(PWM_STEP);
  localparam int SAMP_W = $clog2(SAMPLE);

  // Drive decode: {oe, out, pull_up, pull_down}
  function automatic logic [3:0] drive(input logic [2:0] mode, input logic lvl);
    case (mode)
      MODE_HI_PD:  drive = lvl ? 4'b1100 : 4'b0001;
      MODE_STRONG: drive = {1'b1, lvl, 2'b00};
      MODE_PU_LO:  drive = lvl ? 4'b0010 : 4'b1000;
      MODE_SHI_Z:  drive = lvl ? 4'b1100 : 4'b0000;
      MODE_SLOW:   drive = {1'b1, lvl, 2'b00};
      MODE_Z_SLO:  drive = lvl ? 4'b0000 : 4'b1000;
      default:     drive = 4'b0000;
    endcase
  endfunction : drive

  function automatic logic is_slow(input logic [2:0] mode);
    is_slow = (mode == MODE_SHI_Z) || (mode == MODE_SLOW) || (mode == MODE_Z_SLO);
  endfunction : is_slow

  // Pin synchroniser
  logic [NGPIO-1:0] sync1_q;
  logic [NGPIO-1:0] sync2_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= gpio_in;
      sync2_q <= sync1_q;
    end
  end

  // PWM step and sample timers
  logic [STEP_W-1:0] step_cnt_q;
  logic [6:0]        pct_q;
  logic [SAMP_W-1:0] samp_cnt_q;
  wire               step_tick = (step_cnt_q == STEP_W'(PWM_STEP - 1));
  wire               samp_tick = (samp_cnt_q == SAMP_W'(SAMPLE - 1));

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      step_cnt_q <= '0;
      pct_q      <= '0;
      samp_cnt_q <= '0;
    end else begin
      step_cnt_q <= step_tick ? '0 : step_cnt_q + 1'b1;
      if (step_tick) begin
        pct_q <= (pct_q == 7'(PWM_STEPS - 1)) ? '0 : pct_q + 1'b1;
      end
      samp_cnt_q <= samp_tick ? '0 : samp_cnt_q + 1'b1;
    end
  end

  // Command and response registers
  logic [7:0] type_q;
  logic [7:0] arg0_q;
  logic [7:0] arg1_q;
  logic [7:0] arg2_q;
  logic [1:0] len_q;
  logic [7:0] resp_type_q;
  logic [2:0] resp_len_q;
  logic [7:0] resp_q [4];

  // Pin settings, live and boot copy
  logic [7:0]       value_q      [NPINS];
  logic [3:0]       cfg_q        [NPINS];
  logic [7:0]       boot_value_q [NPINS];
  logic [3:0]       boot_cfg_q   [NPINS];
  logic             restore_q;
  logic [NPINS-1:0] samp_q;
  logic [NPINS-1:0] rise_q;
  logic [NPINS-1:0] fall_q;
  logic [NLED-1:0]  led_q;

  // Command decode
  wire exec     = wr_en && (addr == ADDR_EXEC);
  // Length rides on the execute write itself, so the stored copy is one command late
  wire [1:0] len_now = exec ? wdata[1:0] : len_q;
  wire idx_ok   = (arg0_q <= IDX_MAX);
  wire val_ok   = (arg1_q <= VAL_HIGH);
  wire cfg_ok   = ((arg2_q & CFG_RSVD_MASK) == 8'h00) &&
                  (arg2_q[2:0] != MODE_RSVD);
  wire len_ok   = (len_now == LEN_VALUE) || ((len_now == LEN_CONFIG) && cfg_ok);
  wire set_ok   = (type_q == CMD_SET) && idx_ok && val_ok && len_ok;
  wire query_ok = (type_q == CMD_QUERY) && (len_now == LEN_QUERY) && idx_ok;
  wire store_ok = (type_q == CMD_STORE) && (len_now == LEN_STORE);
  wire cmd_ok   = set_ok || query_ok || store_ok;
  wire [3:0] pin = arg0_q[3:0];

  // Selected pin view for the query answer
  logic [7:0] sel_value;
  logic [3:0] sel_cfg;
  logic       sel_samp;
  logic       sel_rise;
  logic       sel_fall;

  always_comb begin
    sel_value = VAL_LOW;
    sel_cfg   = '0;
    sel_samp  = 1'b0;
    sel_rise  = 1'b0;
    sel_fall  = 1'b0;
    for (int i = 0; i < NPINS; i++) begin
      if (4'(i) == pin) begin
        sel_value = value_q[i];
        sel_cfg   = cfg_q[i];
        sel_samp  = samp_q[i];
        sel_rise  = rise_q[i];
        sel_fall  = fall_q[i];
      end
    end
  end

  // Requested level per pin; default function takes over when F is clear
  logic [NPINS-1:0] req_level;

  always_comb begin
    for (int i = 0; i < NPINS; i++) begin
      if (value_q[i] == VAL_LOW) begin
        req_level[i] = 1'b0;
      end else if (value_q[i] >= VAL_HIGH) begin
        req_level[i] = 1'b1;
      end else begin
        req_level[i] = ({1'b0, pct_q} < value_q[i]);
      end
    end
    for (int g = 0; g < NGPIO; g++) begin
      if (!cfg_q[g][CFG_FUNC_BIT]) begin
        req_level[g] = dflt_level[g];
      end
    end
  end

  // Level seen by the sampler: pins from the synchroniser, LEDs from their driver
  wire [NPINS-1:0] pin_now = {led_q, sync2_q};
  wire [NPINS-1:0] rise_ev = {NPINS{samp_tick}} & pin_now & ~samp_q;
  wire [NPINS-1:0] fall_ev = {NPINS{samp_tick}} & ~pin_now & samp_q;
  wire [NPINS-1:0] clr_mask = (exec && query_ok) ? (NPINS'(1) << pin) : '0;

  // Sampling and edge latches; a new edge beats a clear in the same cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      samp_q <= '0;
      rise_q <= '0;
      fall_q <= '0;
    end else begin
      if (samp_tick) begin
        samp_q <= pin_now;
      end
      rise_q <= (rise_q & ~clr_mask) | rise_ev;
      fall_q <= (fall_q & ~clr_mask) | fall_ev;
    end
  end

  // Command register writes
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      type_q <= '0;
      arg0_q <= '0;
      arg1_q <= '0;
      arg2_q <= '0;
      len_q  <= '0;
    end else if (wr_en) begin
      case (addr)
        ADDR_CMD_TYPE: type_q <= wdata;
        ADDR_ARG0:     arg0_q <= wdata;
        ADDR_ARG1:     arg1_q <= wdata;
        ADDR_ARG2:     arg2_q <= wdata;
        ADDR_EXEC:     len_q  <= wdata[1:0];
        default:       ;
      endcase
    end
  end

  // Response generation; stands until the next execute
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      resp_type_q <= '0;
      resp_len_q  <= RLEN_NONE;
      for (int k = 0; k < 4; k++) begin
        resp_q[k] <= '0;
      end
    end else if (exec) begin
      resp_type_q <= cmd_ok ? (type_q | RESP_FLAG) : (type_q | ERR_FLAG);
      resp_len_q  <= query_ok ? RLEN_QUERY : RLEN_NONE;
      resp_q[0]   <= query_ok ? arg0_q : 8'h00;
      resp_q[1]   <= query_ok ? {5'h00, sel_rise, sel_fall, sel_samp} : 8'h00;
      resp_q[2]   <= query_ok ? sel_value : 8'h00;
      resp_q[3]   <= query_ok ? {4'h0, sel_cfg} : 8'h00;
    end
  end

  // Boot copy survives rst_n; only power-on returns it to factory
  always_ff @(posedge clock or negedge por_n) begin
    if (!por_n) begin
      for (int i = 0; i < NPINS; i++) begin
        boot_value_q[i] <= FACTORY_VALUE;
        boot_cfg_q[i]   <= factory_cfg(i);
      end
    end else if (exec && store_ok) begin
      for (int i = 0; i < NPINS; i++) begin
        boot_value_q[i] <= value_q[i];
        boot_cfg_q[i]   <= cfg_q[i];
      end
    end
  end

  // Live settings: reload boot copy after reset, then apply set commands
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      restore_q <= 1'b1;
      for (int i = 0; i < NPINS; i++) begin
        value_q[i] <= FACTORY_VALUE;
        cfg_q[i]   <= factory_cfg(i);
      end
    end else begin
      restore_q <= 1'b0;
      for (int i = 0; i < NPINS; i++) begin
        if (restore_q) begin
          value_q[i] <= boot_value_q[i];
          cfg_q[i]   <= boot_cfg_q[i];
        end else if (exec && set_ok && (4'(i) == pin)) begin
          value_q[i] <= arg1_q;
          if (len_now == LEN_CONFIG) begin
            cfg_q[i] <= arg2_q[3:0];
          end
        end
      end
    end
  end

  // Pin and LED drivers, registered so the pads never see decode glitches
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      gpio_oe        <= '0;
      gpio_out       <= '0;
      gpio_pull_up   <= '0;
      gpio_pull_down <= '0;
      gpio_slow      <= '0;
      led_q          <= '0;
    end else begin
      for (int g = 0; g < NGPIO; g++) begin
        {gpio_oe[g], gpio_out[g], gpio_pull_up[g], gpio_pull_down[g]} <=
          drive(cfg_q[g][2:0], req_level[g]);
        gpio_slow[g] <= is_slow(cfg_q[g][2:0]);
      end
      led_q <= req_level[NPINS-1:NGPIO];
    end
  end

  assign led_out          = led_q;
  assign host_power_sense = sync2_q[1];

  // Read mux; unmapped indices read zero
  logic [7:0] rd_mux;

  always_comb begin
    case (addr)
      ADDR_CMD_TYPE:  rd_mux = type_q;
      ADDR_ARG0:      rd_mux = arg0_q;
      ADDR_ARG1:      rd_mux = arg1_q;
      ADDR_ARG2:      rd_mux = arg2_q;
      ADDR_EXEC:      rd_mux = {6'h00, len_q};
      ADDR_RESP_TYPE: rd_mux = resp_type_q;
      ADDR_RESP_LEN:  rd_mux = {5'h00, resp_len_q};
      ADDR_RESP0:     rd_mux = resp_q[0];
      ADDR_RESP1:     rd_mux = resp_q[1];
      ADDR_RESP2:     rd_mux = resp_q[2];
      ADDR_RESP3:     rd_mux = resp_q[3];
      default:        rd_mux = 8'h00;
    endcase
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= '0;
    end else begin
      rdata <= rd_en ? rd_mux : 8'h00;
    end
  end

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  chk_set_ack: assert property (exec && set_ok |=>
    resp_type_q == (CMD_SET | RESP_FLAG) && resp_len_q == RLEN_NONE)
    else $error("set not acknowledged");
  chk_mode_reject: assert property (exec && type_q == CMD_SET &&
    len_now == LEN_CONFIG && arg2_q[2:0] == MODE_RSVD |=>
    resp_type_q == (CMD_SET | ERR_FLAG) && sel_cfg == $past(sel_cfg))
    else $error("reserved drive mode applied");
  chk_value_only: assert property (exec && set_ok &&
    len_now == LEN_VALUE && !restore_q |=>
    sel_cfg == $past(sel_cfg) && sel_value == $past(arg1_q))
    else $error("value-only set changed config");
  chk_query_resp: assert property (exec && query_ok |=>
    resp_type_q == (CMD_QUERY | RESP_FLAG) && resp_len_q == RLEN_QUERY &&
    resp_q[0] == $past(arg0_q) && resp_q[2] == $past(sel_value))
    else $error("query answer wrong");
  chk_edge_clear: assert property (exec && query_ok && !samp_tick |=>
    !sel_rise && !sel_fall)
    else $error("edges not cleared by query");
  chk_state_bits: assert property (exec && query_ok |=> resp_q[1][7:3] == 5'h00 &&
    resp_q[1][0] == $past(sel_samp) && resp_q[1][2] == $past(sel_rise))
    else $error("state byte wrong");
  chk_rise_latch: assert property (samp_tick && pin_now[0] && !samp_q[0] |=>
    rise_q[0] && samp_q[0])
    else $error("rising edge lost");
  chk_bad_index: assert property (exec && type_q == CMD_QUERY && arg0_q > IDX_MAX |=>
    resp_type_q == (CMD_QUERY | ERR_FLAG))
    else $error("bad index accepted");
  chk_full_high: assert property (cfg_q[4] == {1'b1, MODE_STRONG} &&
    value_q[4] == VAL_HIGH |=> gpio_out[4] && gpio_oe[4])
    else $error("value 100 not driven high");
  chk_pullup_mode: assert property (cfg_q[0][2:0] == MODE_PU_LO && req_level[0] |=>
    gpio_pull_up[0] && !gpio_oe[0])
    else $error("pull-up mode not resistive");
  chk_boot_store: assert property (exec && store_ok && !restore_q |=>
    boot_cfg_q[0] == $past(cfg_q[0]) && boot_value_q[0] == $past(value_q[0]))
    else $error("boot copy not stored");

  cov_set_cfg:   cover property (exec && set_ok && len_now == LEN_CONFIG);
  cov_query_rf:  cover property (exec && query_ok && sel_rise && sel_fall);
  cov_rejected:  cover property (exec && !cmd_ok);
endmodule : packet_gpio_port

//--- tb/pad_model.sv
`timescale 1ns/1ps
// Board side of the five pins: drivers, pull resistors and open nets
module pad_model (
  // Clock
  input  wire logic       clock,
  // Block side
  input  wire logic [4:0] gpio_out,
  input  wire logic [4:0] gpio_oe,
  input  wire logic [4:0] gpio_pull_up,
  input  wire logic [4:0] gpio_pull_down,
  // Board side
  input  wire logic [4:0] ext_en,
  input  wire logic [4:0] ext_lvl,
  output logic      [4:0] pad
);
  logic [4:0] wobble_q = 5'h0a;

  // An open net wanders, so a missing pull never reads as a steady level
  always @(posedge clock) begin
    wobble_q <= ~wobble_q;
  end

  // Strong drive wins over the board, the board over the resistors
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      if (gpio_oe[i]) pad[i] = gpio_out[i];
      else if (ext_en[i]) pad[i] = ext_lvl[i];
      else if (gpio_pull_up[i]) pad[i] = 1'b1;
      else if (gpio_pull_down[i]) pad[i] = 1'b0;
      else pad[i] = wobble_q[i];
    end
  end
endmodule : pad_model

//--- tb/tb.sv
`timescale 1ns/1ps
module tb;
  import gpio_port_pkg::*;
  // Shortened counts keep the run small
  localparam int PWM = 4;
  localparam int SMP = 16;
  localparam int SETTLE = 2 * SMP + 8;
  localparam logic [7:0] DRV_TBL [8] = '{8'hc1, 8'hc8, 8'h00, 8'h28, 8'hc0, 8'hc8, 8'h00, 8'h08};
  localparam int DUTY [3] = '{1, 25, 99};

  logic       clock = 1'b0;
  logic       rst_n, por_n, wr_en, rd_en, host_power_sense;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, led_out, rt, rl, tmp;
  logic [7:0] r [4];
  logic [4:0] gpio_in, gpio_out, gpio_oe, gpio_pull_up, gpio_pull_down, gpio_slow;
  logic [4:0] dflt_level, ext_en, ext_lvl;
  int         err_total, n_tests;

  always #2.5 clock = ~clock;

  packet_gpio_port #(.PWM_STEP(PWM), .SAMPLE(SMP)) dut_u (
    .clock(clock), .rst_n(rst_n), .por_n(por_n), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .gpio_in(gpio_in),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe), .gpio_pull_up(gpio_pull_up),
    .gpio_pull_down(gpio_pull_down), .gpio_slow(gpio_slow), .led_out(led_out),
    .dflt_level(dflt_level), .host_power_sense(host_power_sense));

  pad_model pad_u (
    .clock(clock), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .gpio_pull_up(gpio_pull_up),
    .gpio_pull_down(gpio_pull_down), .ext_en(ext_en), .ext_lvl(ext_lvl), .pad(gpio_in));

  task automatic end_of_test;
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic chk_count(input string nm, input int e, input int g);
    n_tests++;
    if (g != e) begin
      err_total++;
      $display("Error %s expected %0d seen %0d", nm, e, g);
    end
  endtask : chk_count

  // Bus cycles: one strobe cycle each, read data taken in the cycle after
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    #1 d = rdata;
  endtask : rd

  task automatic cmd(input logic [7:0] t, i, v, c, input logic [1:0] n);
    wr(ADDR_CMD_TYPE, t);
    wr(ADDR_ARG0, i);
    wr(ADDR_ARG1, v);
    wr(ADDR_ARG2, c);
    wr(ADDR_EXEC, {6'h0, n});
    rd(ADDR_RESP_TYPE, rt);
    rd(ADDR_RESP_LEN, rl);
  endtask : cmd

  task automatic set(input logic [7:0] i, v, c, input logic [1:0] n, input logic [7:0] et);
    cmd(CMD_SET, i, v, c, n);
    chk("set type", et, rt);
    chk("set len", 8'h00, rl);
  endtask : set

  task automatic query(input logic [7:0] i);
    cmd(CMD_QUERY, i, 8'h00, 8'h00, LEN_QUERY);
    for (int k = 0; k < 4; k++) rd(ADDR_RESP0 + 4'(k), r[k]);
    chk("query type", 8'h63, rt);
    chk("query len", 8'h04, rl);
    chk("query idx", i, r[0]);
  endtask : query

  // Pad drive as {oe, out, pull up, pull down}
  task automatic drv(input int p, input logic [3:0] e);
    chk("drive", {4'h0, e}, {4'h0, gpio_oe[p], gpio_out[p], gpio_pull_up[p], gpio_pull_down[p]});
  endtask : drv

  task automatic t_factory;
    query(8'h02);
    chk("cfg pin2", 8'h01, r[3]);
    chk("val pin2", 8'h00, r[2]);
    query(8'h01);
    chk("cfg pin1", 8'h02, r[3]);
    drv(2, 4'h8);
    rd(ADDR_ARG0, tmp);
    chk("arg readback", 8'h01, tmp);
    rd(4'hf, tmp);
    chk("unmapped", 8'h00, tmp);
    @(posedge clock);
    ext_en[1]  <= 1'b1;
    ext_lvl[1] <= 1'b1;
    repeat (6) @(posedge clock);
    #1 chk("sense", 8'h01, {7'h0, host_power_sense});
    $display("factory done");
  endtask : t_factory

  // Default function follows the host level until the pin is claimed
  task automatic t_default_func;
    @(posedge clock);
    dflt_level[3] <= 1'b1;
    repeat (4) @(posedge clock);
    #1 drv(3, 4'hc);
    set(8'h03, VAL_LOW, 8'h09, LEN_CONFIG, 8'h62);
    drv(3, 4'h8);
    set(8'h03, VAL_LOW, 8'h01, LEN_CONFIG, 8'h62);
    drv(3, 4'hc);
    $display("default function done");
  endtask : t_default_func

  task automatic t_modes;
    for (int m = 0; m < 8; m++) begin
      if (m == 6) continue;
      set(8'h04, VAL_HIGH, 8'h08 | 8'(m), LEN_CONFIG, 8'h62);
      drv(4, DRV_TBL[m][7:4]);
      chk("slow", {7'h0, m inside {4, 5, 7}}, {7'h0, gpio_slow[4]});
      set(8'h04, VAL_LOW, 8'h00, LEN_VALUE, 8'h62);
      drv(4, DRV_TBL[m][3:0]);
    end
    query(8'h04);
    chk("cfg kept", 8'h0f, r[3]);
    $display("drive modes done");
  endtask : t_modes

  task automatic t_refuse;
    set(8'h04, VAL_HIGH, 8'h0e, LEN_CONFIG, 8'he2);
    set(8'h0d, VAL_LOW, 8'h00, LEN_VALUE, 8'he2);
    set(8'h00, 8'h65, 8'h00, LEN_VALUE, 8'he2);
    set(8'h00, 8'hff, 8'h00, LEN_VALUE, 8'he2);
    set(8'h00, VAL_LOW, 8'h1a, LEN_CONFIG, 8'he2);
    set(8'h00, VAL_LOW, 8'h00, LEN_QUERY, 8'he2);
    cmd(CMD_QUERY, 8'h0d, 8'h00, 8'h00, LEN_QUERY);
    chk("bad query", 8'he3, rt);
    query(8'h04);
    chk("cfg after refuse", 8'h0f, r[3]);
    chk("val after refuse", 8'h00, r[2]);
    $display("refusals done");
  endtask : t_refuse

  task automatic t_led;
    set(8'h05, VAL_HIGH, 8'h00, LEN_VALUE, 8'h62);
    chk("led first", 8'h01, led_out);
    set(8'h0c, VAL_HIGH, 8'h00, LEN_VALUE, 8'h62);
    chk("led last", 8'h81, led_out);
    query(8'h0c);
    chk("led value", 8'h64, r[2]);
    $display("leds done");
  endtask : t_led

  // A full PWM period holds exactly duty steps of high level
  task automatic t_pwm;
    int hi;
    foreach (DUTY[k]) begin
      set(8'h01, 8'(DUTY[k]), 8'h09, LEN_CONFIG, 8'h62);
      hi = 0;
      repeat (100 * PWM) begin
        @(negedge clock);
        hi += int'(gpio_out[1]);
      end
      chk_count("pwm high", DUTY[k] * PWM, hi);
    end
    set(8'h01, VAL_LOW, 8'h02, LEN_CONFIG, 8'h62);
    $display("pwm done");
  endtask : t_pwm

  task automatic t_edges;
    @(posedge clock);
    ext_en[0]  <= 1'b1;
    ext_lvl[0] <= 1'b0;
    set(8'h00, VAL_HIGH, 8'h0b, LEN_CONFIG, 8'h62);
    drv(0, 4'h2);
    repeat (SETTLE) @(posedge clock);
    query(8'h00);
    repeat (SETTLE) @(posedge clock);
    query(8'h00);
    chk("quiet", 8'h00, r[1]);
    @(posedge clock);
    ext_en[0] <= 1'b0;
    repeat (SETTLE) @(posedge clock);
    query(8'h00);
    chk("rise", 8'h05, r[1]);
    query(8'h00);
    chk("rise cleared", 8'h01, r[1]);
    @(posedge clock);
    ext_en[0] <= 1'b1;
    repeat (SETTLE) @(posedge clock);
    query(8'h00);
    chk("fall", 8'h02, r[1]);
    $display("edges done");
  endtask : t_edges

  task automatic t_store;
    cmd(CMD_STORE, 8'h00, 8'h00, 8'h00, LEN_STORE);
    chk("store", 8'h44, rt);
    cmd(CMD_STORE, 8'h00, 8'h00, 8'h00, LEN_QUERY);
    chk("bad store", 8'hc4, rt);
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    query(8'h00);
    chk("boot cfg", 8'h0b, r[3]);
    chk("boot val", 8'h64, r[2]);
    drv(0, 4'h2);
    $display("store done");
  endtask : t_store

  // Bounded run: a hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge clock);
    err_total++;
    $display("Error timeout expected finish seen hang");
    end_of_test();
  end

  initial begin
    {rst_n, por_n, wr_en, rd_en} = 4'h0;
    addr       = 4'h0;
    wdata      = 8'h00;
    dflt_level = 5'h00;
    ext_en     = 5'h00;
    ext_lvl    = 5'h00;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    repeat (3) @(posedge clock);
    t_factory();
    t_default_func();
    t_modes();
    t_refuse();
    t_led();
    t_pwm();
    t_edges();
    t_store();
    end_of_test();
  end
endmodule : tb
